// ==== verilog/lp_mode_pkg.sv ====
/*
  Package for the power-mode controller: mode codes, voltage ranges,
  wait-state limits, frequency limits and wakeup timing.
  Assumes frequencies arrive in kHz from the clock tree logic.
*/
package lp_mode_pkg;

  // Requested power modes
  typedef enum logic [3:0] {
    REQ_RUN         = 4'h0,
    REQ_LP_RUN      = 4'h1,
    REQ_SLEEP       = 4'h2,
    REQ_STOP_MAIN   = 4'h3,
    REQ_STOP_LP     = 4'h4,
    REQ_STOP_DEEP   = 4'h5,
    REQ_STANDBY     = 4'h6,
    REQ_SHUTDOWN    = 4'h7
  } mode_req_t;

  // Voltage ranges
  localparam logic [1:0] RANGE_NORMAL  = 2'h0;
  localparam logic [1:0] RANGE_REDUCED = 2'h1;
  localparam logic [1:0] RANGE_BOOST   = 2'h2;

  // Wait-state limits in kHz
  localparam logic [17:0] NORM_STEP_KHZ  = 18'd20000;
  localparam logic [17:0] NORM_MAX_KHZ   = 18'd100000;
  localparam logic [17:0] RED_WS0_KHZ    = 18'd8000;
  localparam logic [17:0] RED_WS1_KHZ    = 18'd16000;
  localparam logic [17:0] RED_WS2_KHZ    = 18'd26000;
  localparam logic [17:0] BOOST_MAX_KHZ  = 18'd120000;
  localparam logic [17:0] LP_MAX_KHZ     = 18'd2000;
  localparam logic [2:0]  BOOST_WAIT_STATES = 3'h5;

  // Timing
  localparam int CLK_MHZ          = 50;
  localparam int SLEEP_EXIT_CYC   = 6;
  localparam int STOP_WAKE_NS     = 1000;
  localparam int DEEP_SRAM_NS     = 5000;
  localparam int DEEP_FLASH_NS    = 8000;
  localparam int STOP_WAKE_CYC    = STOP_WAKE_NS * CLK_MHZ / 1000;
  localparam int DEEP_SRAM_CYC    = DEEP_SRAM_NS * CLK_MHZ / 1000;
  localparam int DEEP_FLASH_CYC   = DEEP_FLASH_NS * CLK_MHZ / 1000;
  localparam int WAKE_PINS        = 5;

endpackage

// ==== verilog/low_power_mode_control.sv ====
/*
  Power-mode controller: wait states, regulator choice, clock and
  memory gating per mode, wakeup source filtering and exit timing.
  Assumes all inputs except wakeup pins and the reset pin come from logic on clk_sys.
*/
`timescale 1ns/1ps

// Functional notes
// - Normal range: one wait state per 20 MHz step above 20, four at 100.
// - Reduced range: 0/1/2 wait states up to 8/16/26 MHz, above refused.
// - Boost range up to 120 MHz always uses 5 wait states.
// - Brown-out and watchdog may stay on in every mode but shutdown.
// - Low-power run/sleep use low-power regulator, clock at most 2 MHz.
// - Flash off in low-power sleep, or low-power run executing from SRAM.
// - Batch acquisition keeps only DMA, comms and SRAM clocks; flash off.
// - Batch acquisition at or below 2 MHz turns main regulator off.
// - In low-power sleep, I2C and serial may use the 16 MHz oscillator.
// - Stop halts fast oscillators; peripherals may request 16 MHz on demand.
// - Stop exit restarts from multispeed oscillator within about 1 us.
// - Deep stop wakes in about 5 us from SRAM, 8 us from flash.
// - Brown-out reset always enabled during standby.
// - Standby loses SRAM except the second bank when its retention is selected.
// - Standby holds per-pin pull-up or pull-down selections.
// - Standby exits on wakeup pins, reset pin, watchdog or clock event.
// - Shutdown: regulators and monitor off; wake by pins, reset, crystal clock.
// - Shutdown pull configuration discarded on exit.
// - Sleep modes end on any interrupt or event, resuming 6 cycles later.
// - Low-power regulator state means main off, low-power on; first stop mode keeps main.
// - Serial receivers wake stop modes on start, address or frame.
// - I2C address match wakes stop modes.
// - Low-power run lets independent-clock peripherals use 16 MHz.
module low_power_mode_control
  import lp_mode_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                mode_req_valid,
  input  wire mode_req_t           mode_req,
  input  wire logic [1:0]          volt_range,
  input  wire logic [17:0]         sysclk_khz,
  input  wire logic                exec_from_sram,
  input  wire logic                batch_acquisition_submode,
  input  wire logic                sram2_retain_sel,
  input  wire logic                rtc_on_slow_crystal,
  input  wire logic [NUM_PINS-1:0] pull_up_sel,
  input  wire logic [NUM_PINS-1:0] pull_dn_sel,
  input  wire logic                irq_or_event,
  input  wire logic [WAKE_PINS-1:0] wakeup_pin,
  input  wire logic                reset_pin_n,
  input  wire logic                wdg_wake,
  input  wire logic                rtc_wake,
  input  wire logic                serial_start,
  input  wire logic                serial_addr,
  input  wire logic                serial_frame,
  input  wire logic                i2c_addr_match,
  input  wire logic                periph_osc_req,
  input  wire logic                resume_in_flash,
  output logic [2:0]               flash_wait_states,
  output logic                     freq_error,
  output logic                     main_regulator_state,
  output logic                     lowpower_regulator_state,
  output logic                     cpu_clk_en,
  output logic                     flash_pd,
  output logic                     flash_clk_en,
  output logic                     sram1_pwr,
  output logic                     sram2_pwr,
  output logic                     dma_clk_en,
  output logic                     comm_clk_en,
  output logic                     other_periph_clk_en,
  output logic                     fast_osc_en,
  output logic                     internal_16m_osc,
  output logic                     multispeed_internal_osc,
  output logic                     brownout_reset,
  output logic                     independent_watchdog,
  output logic [NUM_PINS-1:0]      pull_up_out,
  output logic [NUM_PINS-1:0]      pull_dn_out,
  output logic                     serial_wake_irq,
  output logic                     i2c_wake_irq,
  output logic                     sys_reset_req,
  output logic                     cpu_resume
);

  // Refuse a pin count that the pull logic cannot hold
  if (NUM_PINS < 1) begin : g_pins_chk
    $error("NUM_PINS must be positive");
  end

  // One-hot controller states
  typedef enum logic [7:0] {
    ST_RUN      = 8'h01,
    ST_LP_RUN   = 8'h02,
    ST_SLEEP    = 8'h04,
    ST_STOP     = 8'h08,
    ST_STANDBY  = 8'h10,
    ST_SHUTDOWN = 8'h20,
    ST_WAKE     = 8'h40,
    ST_RESET    = 8'h80
  } state_t;

  // Sequencer state, stop flavour, exit counter and sleep options
  state_t     state_q;
  mode_req_t  stop_kind_q;
  logic       lp_sleep_q;
  logic [9:0] wait_q;
  logic       batch_q;

  // Two-stage synchronisers for pins
  logic [WAKE_PINS:0] pin_s1_q;
  logic [WAKE_PINS:0] pin_s2_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {~reset_pin_n, wakeup_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  // Any wake pin, and the reset pin seen active
  logic pin_wake;
  logic rst_pin_wake;
  assign pin_wake     = |pin_s2_q[WAKE_PINS-1:0];
  assign rst_pin_wake = pin_s2_q[WAKE_PINS];

  // Wait states and legality from range and frequency
  logic [2:0] latency_d;
  logic       err_d;
  always_comb begin
    latency_d = 3'h0;
    err_d     = 1'b0;
    case (volt_range)
      RANGE_NORMAL: begin
        if (sysclk_khz <= NORM_STEP_KHZ)             latency_d = 3'h0;
        else if (sysclk_khz <= 18'(2*NORM_STEP_KHZ)) latency_d = 3'h1;
        else if (sysclk_khz <= 18'(3*NORM_STEP_KHZ)) latency_d = 3'h2;
        else if (sysclk_khz <= 18'(4*NORM_STEP_KHZ)) latency_d = 3'h3;
        else begin
          latency_d = 3'h4;
          err_d     = sysclk_khz > NORM_MAX_KHZ;
        end
      end
      RANGE_REDUCED: begin
        if (sysclk_khz <= RED_WS0_KHZ)      latency_d = 3'h0;
        else if (sysclk_khz <= RED_WS1_KHZ) latency_d = 3'h1;
        else begin
          latency_d = 3'h2;
          err_d     = sysclk_khz > RED_WS2_KHZ;
        end
      end
      RANGE_BOOST: begin
        latency_d = BOOST_WAIT_STATES;
        err_d     = sysclk_khz > BOOST_MAX_KHZ;
      end
      default: err_d = 1'b1;
    endcase
    // Low-power modes cap the clock whatever the range
    if ((state_q == ST_LP_RUN || lp_sleep_q) && sysclk_khz > LP_MAX_KHZ)
      err_d = 1'b1;
  end

  // Register wait states and speed error
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_wait_states <= 3'h0;
      freq_error        <= 1'b0;
    end else begin
      flash_wait_states <= latency_d;
      freq_error        <= err_d;
    end
  end

  // Wakeup qualification per mode
  logic stop_wake;
  logic standby_wake;
  logic shutdown_wake;
  assign stop_wake     = irq_or_event | pin_wake | rst_pin_wake | rtc_wake | wdg_wake
                       | serial_start | serial_addr | serial_frame
                       | i2c_addr_match;
  assign standby_wake  = pin_wake | rst_pin_wake | wdg_wake | rtc_wake;
  assign shutdown_wake = pin_wake | rst_pin_wake
                       | (rtc_wake & rtc_on_slow_crystal);

  // Mode sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q     <= ST_RUN;
      stop_kind_q <= REQ_RUN;
      lp_sleep_q  <= 1'b0;
      batch_q     <= 1'b0;
      wait_q      <= 10'h0;
    end else begin
      case (state_q)
        ST_RUN, ST_LP_RUN: begin
          if (mode_req_valid) begin
            case (mode_req)
              REQ_RUN:    state_q <= ST_RUN;
              REQ_LP_RUN: state_q <= ST_LP_RUN;
              REQ_SLEEP: begin
                state_q    <= ST_SLEEP;
                batch_q    <= batch_acquisition_submode;
                // Low-power sleep from low-power run or slow batch acquisition
                lp_sleep_q <= (state_q == ST_LP_RUN)
                            | (batch_acquisition_submode
                               & (sysclk_khz <= LP_MAX_KHZ));
              end
              REQ_STOP_MAIN, REQ_STOP_LP, REQ_STOP_DEEP: begin
                state_q     <= ST_STOP;
                stop_kind_q <= mode_req;
              end
              REQ_STANDBY:  state_q <= ST_STANDBY;
              REQ_SHUTDOWN: state_q <= ST_SHUTDOWN;
              default:      state_q <= state_q;
            endcase
          end
        end
        // Any interrupt or event ends sleep after the fixed exit delay
        ST_SLEEP: begin
          if (irq_or_event) begin
            state_q <= ST_WAKE;
            wait_q  <= 10'(SLEEP_EXIT_CYC - 1);
          end
        end
        // Deep stop exit time depends on where execution resumes
        ST_STOP: begin
          if (stop_wake) begin
            state_q <= ST_WAKE;
            if (stop_kind_q == REQ_STOP_DEEP)
              wait_q <= resume_in_flash ? 10'(DEEP_FLASH_CYC - 1)
                                        : 10'(DEEP_SRAM_CYC - 1);
            else
              wait_q <= 10'(STOP_WAKE_CYC - 1);
          end
        end
        ST_STANDBY: if (standby_wake) state_q <= ST_RESET;
        ST_SHUTDOWN: if (shutdown_wake) state_q <= ST_RESET;
        ST_WAKE: begin
          if (wait_q == 10'h0) begin
            // Resume in low-power run after low-power sleep, otherwise in run
            state_q     <= lp_sleep_q ? ST_LP_RUN : ST_RUN;
            lp_sleep_q  <= 1'b0;
            batch_q     <= 1'b0;
            stop_kind_q <= REQ_RUN;
          end else begin
            wait_q <= wait_q - 10'h1;
          end
        end
        // One cycle of reset request, then run
        ST_RESET: begin
          state_q     <= ST_RUN;
          stop_kind_q <= REQ_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Regulator, clock and memory controls per state
  logic lp_reg_d;
  logic in_stop;
  assign in_stop  = state_q == ST_STOP;
  // Low-power regulator alone in low-power modes and the deeper stops
  assign lp_reg_d = state_q == ST_LP_RUN || (state_q == ST_SLEEP && lp_sleep_q)
                  || (in_stop && stop_kind_q != REQ_STOP_MAIN);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_regulator_state     <= 1'b1;
      lowpower_regulator_state <= 1'b0;
      cpu_clk_en               <= 1'b1;
      flash_pd                 <= 1'b0;
      flash_clk_en             <= 1'b1;
      sram1_pwr                <= 1'b1;
      sram2_pwr                <= 1'b1;
      dma_clk_en               <= 1'b1;
      comm_clk_en              <= 1'b1;
      other_periph_clk_en      <= 1'b1;
      fast_osc_en              <= 1'b1;
      internal_16m_osc         <= 1'b1;
      multispeed_internal_osc  <= 1'b1;
      brownout_reset           <= 1'b1;
      independent_watchdog     <= 1'b1;
    end else begin
      // Main off whenever low-power regulator or off modes
      main_regulator_state     <= ~lp_reg_d & state_q != ST_STANDBY
                                & state_q != ST_SHUTDOWN;
      lowpower_regulator_state <= lp_reg_d | state_q == ST_STANDBY;
      cpu_clk_en   <= state_q == ST_RUN || state_q == ST_LP_RUN;
      flash_pd     <= (state_q == ST_SLEEP && (lp_sleep_q || batch_q))
                    || (state_q == ST_LP_RUN && exec_from_sram)
                    || in_stop || state_q == ST_STANDBY
                    || state_q == ST_SHUTDOWN;
      flash_clk_en <= !((state_q == ST_SLEEP && (lp_sleep_q || batch_q))
                    || (state_q == ST_LP_RUN && exec_from_sram)
                    || in_stop || state_q == ST_STANDBY
                    || state_q == ST_SHUTDOWN);
      sram1_pwr    <= state_q != ST_STANDBY && state_q != ST_SHUTDOWN;
      sram2_pwr    <= state_q != ST_SHUTDOWN
                    && (state_q != ST_STANDBY || sram2_retain_sel);
      dma_clk_en   <= state_q != ST_STOP && state_q != ST_STANDBY
                    && state_q != ST_SHUTDOWN;
      comm_clk_en  <= state_q != ST_STANDBY && state_q != ST_SHUTDOWN;
      other_periph_clk_en <= !(state_q == ST_SLEEP && batch_q) && !in_stop
                    && state_q != ST_STANDBY && state_q != ST_SHUTDOWN;
      fast_osc_en  <= state_q == ST_RUN;
      // 16 MHz in run, low-power run and sleep, and in stop on peripheral request
      internal_16m_osc <= state_q == ST_RUN || state_q == ST_LP_RUN
                    || state_q == ST_SLEEP
                    || (in_stop && periph_osc_req);
      multispeed_internal_osc <= !in_stop && state_q != ST_STANDBY
                    && state_q != ST_SHUTDOWN;
      brownout_reset       <= state_q != ST_SHUTDOWN;
      independent_watchdog <= state_q != ST_SHUTDOWN;
    end
  end

  // Pull holding and wake signalling
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pull_up_out     <= '0;
      pull_dn_out     <= '0;
      serial_wake_irq <= 1'b0;
      i2c_wake_irq    <= 1'b0;
      sys_reset_req   <= 1'b0;
      cpu_resume      <= 1'b0;
    end else begin
      if (state_q == ST_STANDBY || state_q == ST_SHUTDOWN) begin
        pull_up_out <= pull_up_sel;
        pull_dn_out <= pull_dn_sel;
      end else begin
        pull_up_out <= '0;
        pull_dn_out <= '0;
      end
      serial_wake_irq <= in_stop & (serial_start | serial_addr | serial_frame);
      i2c_wake_irq    <= in_stop & i2c_addr_match;
      sys_reset_req   <= state_q == ST_RESET;
      cpu_resume      <= state_q == ST_WAKE && wait_q == 10'h0;
    end
  end

endmodule // low_power_mode_control

// ==== verification/low_power_mode_control_chk.sv ====
/*
  Port checker for the power-mode controller: assertions and covers.
  Assumes the controller's ports; bound below with the controller's own NUM_PINS.
*/
`timescale 1ns/1ps

module low_power_mode_control_chk
  import lp_mode_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic [1:0]          volt_range,
  input wire logic [17:0]         sysclk_khz,
  input wire logic [2:0]          flash_wait_states,
  input wire logic                freq_error,
  input wire logic                main_regulator_state,
  input wire logic                lowpower_regulator_state,
  input wire logic                cpu_clk_en,
  input wire logic                flash_pd,
  input wire logic                flash_clk_en,
  input wire logic                fast_osc_en,
  input wire logic                multispeed_internal_osc,
  input wire logic                brownout_reset,
  input wire logic [NUM_PINS-1:0] pull_up_out,
  input wire logic [NUM_PINS-1:0] pull_dn_out,
  input wire logic                serial_wake_irq,
  input wire logic                i2c_wake_irq,
  input wire logic                sys_reset_req,
  input wire logic                cpu_resume
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Expected wait states in the normal range
  function automatic logic [2:0] lat_norm(input logic [17:0] k);
    lat_norm = 3'h0;
    for (int i = 1; i < 5; i++) if (k > i * NORM_STEP_KHZ) lat_norm = 3'(i);
  endfunction

  a_wait_normal: assert property (!$past(rst) && $past(volt_range) == RANGE_NORMAL &&
    $past(sysclk_khz) <= NORM_MAX_KHZ |-> flash_wait_states == lat_norm($past(sysclk_khz)))
    else $error("normal range wait states wrong");
  a_wait_reduced: assert property (!$past(rst) && $past(volt_range) == RANGE_REDUCED &&
    $past(sysclk_khz) <= RED_WS2_KHZ |-> flash_wait_states == (($past(sysclk_khz) >
    RED_WS1_KHZ) ? 3'h2 : ($past(sysclk_khz) > RED_WS0_KHZ) ? 3'h1 : 3'h0))
    else $error("reduced range wait states wrong");
  a_reduced_limit: assert property (!$past(rst) && $past(volt_range) == RANGE_REDUCED &&
    $past(sysclk_khz) > RED_WS2_KHZ |-> freq_error) else $error("reduced overspeed not flagged");
  a_wait_boost: assert property (!$past(rst) && $past(volt_range) == RANGE_BOOST &&
    $past(sysclk_khz) <= BOOST_MAX_KHZ |-> flash_wait_states == BOOST_WAIT_STATES)
    else $error("boost wait states wrong");
  a_lp_reg_excl: assert property (lowpower_regulator_state |-> !main_regulator_state)
    else $error("both regulators on");
  a_shutdown_off: assert property (!brownout_reset |->
    !main_regulator_state && !lowpower_regulator_state) else $error("regulator on in shutdown");
  a_stop_fast_off: assert property (!multispeed_internal_osc |-> !fast_osc_en)
    else $error("fast oscillator running in stop");
  a_flash_gate: assert property (flash_pd |-> !flash_clk_en)
    else $error("flash clock on while powered down");
  a_resume_pulse: assert property (cpu_resume |=> !cpu_resume)
    else $error("resume pulse too long");
  a_reset_pulse: assert property ($rose(sys_reset_req) |=> !sys_reset_req)
    else $error("reset request pulse too long");
  a_pulls_running: assert property (cpu_clk_en |->
    pull_up_out == '0 && pull_dn_out == '0) else $error("pulls held while running");

  // Main scenarios reached
  c_resume: cover property (cpu_resume);
  c_reset_req: cover property (sys_reset_req);
  c_freq_err: cover property (freq_error);
  c_serial: cover property (serial_wake_irq);
  c_i2c: cover property (i2c_wake_irq);
endmodule // low_power_mode_control_chk

bind low_power_mode_control low_power_mode_control_chk #(.NUM_PINS(NUM_PINS)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .volt_range(volt_range), .sysclk_khz(sysclk_khz),
  .flash_wait_states(flash_wait_states), .freq_error(freq_error),
  .main_regulator_state(main_regulator_state),
  .lowpower_regulator_state(lowpower_regulator_state), .cpu_clk_en(cpu_clk_en),
  .flash_pd(flash_pd), .flash_clk_en(flash_clk_en), .fast_osc_en(fast_osc_en),
  .multispeed_internal_osc(multispeed_internal_osc), .brownout_reset(brownout_reset),
  .pull_up_out(pull_up_out), .pull_dn_out(pull_dn_out), .serial_wake_irq(serial_wake_irq),
  .i2c_wake_irq(i2c_wake_irq), .sys_reset_req(sys_reset_req), .cpu_resume(cpu_resume));

// ==== verification/low_power_mode_control_tb.sv ====
/*
  Self-checking bench for the power-mode controller: table of clock cases,
  then mode entry, wakeup and reset-restart scenarios.
  Assumes the package constants and a 50 MHz clk_sys.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module low_power_mode_control_tb import lp_mode_pkg::*;;
  typedef struct packed {logic [1:0] vr; logic [17:0] khz; logic [2:0] lat; logic err;} row_t;
  logic clk_sys = 0, rst = 1, mode_req_valid, exec_from_sram, batch_acquisition_submode;
  logic sram2_retain_sel, rtc_on_slow_crystal, irq_or_event, reset_pin_n, wdg_wake, rtc_wake;
  logic serial_start, serial_addr, serial_frame, i2c_addr_match, periph_osc_req, resume_in_flash;
  logic freq_error, main_regulator_state, lowpower_regulator_state, cpu_clk_en, flash_pd;
  logic flash_clk_en, sram1_pwr, sram2_pwr, dma_clk_en, comm_clk_en, other_periph_clk_en;
  logic fast_osc_en, internal_16m_osc, multispeed_internal_osc, brownout_reset, hit;
  logic independent_watchdog, serial_wake_irq, i2c_wake_irq, sys_reset_req, cpu_resume;
  logic [2:0]  flash_wait_states;
  logic [1:0]  volt_range;
  logic [17:0] sysclk_khz;
  logic [4:0]  wakeup_pin;
  logic [15:0] pull_up_sel, pull_dn_sel, pull_up_out, pull_dn_out;
  mode_req_t   mode_req;
  int          bad_count = 0, checks_done = 0, n;
  mode_req_t   stops[4] = '{REQ_STOP_MAIN, REQ_STOP_LP, REQ_STOP_DEEP, REQ_STOP_DEEP};
  int          lims[4] = '{STOP_WAKE_CYC, STOP_WAKE_CYC, DEEP_SRAM_CYC, DEEP_FLASH_CYC};
  row_t rows[16] = '{
    '{2'h0, 18'h04e20, 3'h0, 1'b0}, '{2'h0, 18'h04e21, 3'h1, 1'b0},
    '{2'h0, 18'h09c40, 3'h1, 1'b0}, '{2'h0, 18'h0ea60, 3'h2, 1'b0},
    '{2'h0, 18'h13880, 3'h3, 1'b0}, '{2'h0, 18'h13881, 3'h4, 1'b0},
    '{2'h0, 18'h186a0, 3'h4, 1'b0}, '{2'h0, 18'h186a1, 3'h0, 1'b1},
    '{2'h1, 18'h01f40, 3'h0, 1'b0}, '{2'h1, 18'h01f41, 3'h1, 1'b0},
    '{2'h1, 18'h03e80, 3'h1, 1'b0}, '{2'h1, 18'h06590, 3'h2, 1'b0},
    '{2'h1, 18'h06591, 3'h0, 1'b1}, '{2'h2, 18'h1d4c0, 3'h5, 1'b0},
    '{2'h2, 18'h1d4c1, 3'h0, 1'b1}, '{2'h3, 18'h003e8, 3'h0, 1'b1}};

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  low_power_mode_control dut (.*);

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One-cycle mode request, then let outputs settle
  task req(input mode_req_t m);
    @(negedge clk_sys); mode_req = m; mode_req_valid = 1'b1;
    @(negedge clk_sys); mode_req_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // Count cycles until resume (sel 0) or reset request (sel 1)
  task wait_ev(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (((sel == 0) ? cpu_resume : sys_reset_req) !== 1'b1) begin
      @(posedge clk_sys); #1; cnt++;
      if (cnt > lim) begin
        bad_count++; $display("mismatch wakeup expected 1 seen 0"); give_verdict;
      end
    end
    repeat (4) @(negedge clk_sys);
  endtask

  // Watch that nothing wakes for 20 cycles
  task no_wake;
    hit = 1'b0;
    repeat (20) begin @(posedge clk_sys); #1; hit |= sys_reset_req | cpu_resume; end
    @(negedge clk_sys);
  endtask

  initial begin
    {mode_req_valid, exec_from_sram, batch_acquisition_submode, sram2_retain_sel} = '0;
    {rtc_on_slow_crystal, irq_or_event, wdg_wake, rtc_wake, serial_start} = '0;
    {serial_addr, serial_frame, i2c_addr_match, periph_osc_req, resume_in_flash} = '0;
    {wakeup_pin, pull_up_sel, pull_dn_sel, volt_range} = '0;
    reset_pin_n = 1'b1; mode_req = REQ_RUN; sysclk_khz = 18'h00fa0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK("main reg", 1'b1, main_regulator_state)
    `CHK("watchdog", 1'b1, independent_watchdog)
    foreach (rows[i]) begin
      volt_range = rows[i].vr; sysclk_khz = rows[i].khz;
      repeat (2) @(negedge clk_sys);
      `CHK("freq err", rows[i].err, freq_error)
      if (!rows[i].err) `CHK("wait states", rows[i].lat, flash_wait_states)
    end
    volt_range = RANGE_NORMAL; sysclk_khz = 18'h00fa0;
    // Sleep and wake on an event
    req(REQ_SLEEP);
    `CHK("cpu clk", 1'b0, cpu_clk_en)
    irq_or_event = 1'b1; wait_ev(0, 20, n); irq_or_event = 1'b0;
    `CHK("sleep exit", 1'b1, n >= 5 && n <= 8)
    // Low-power run, overspeed, flash off from SRAM, low-power sleep
    sysclk_khz = 18'h007d0; req(REQ_LP_RUN);
    `CHK("lp reg", 1'b1, lowpower_regulator_state)
    `CHK("osc16 lp run", 1'b1, internal_16m_osc)
    exec_from_sram = 1'b1; sysclk_khz = 18'h007d1; repeat (2) @(negedge clk_sys);
    `CHK("flash pd", 1'b1, flash_pd)
    `CHK("lp overspeed", 1'b1, freq_error)
    sysclk_khz = 18'h007d0; exec_from_sram = 1'b0; req(REQ_SLEEP);
    `CHK("lps main", 1'b0, main_regulator_state)
    `CHK("lps flash", 1'b0, flash_clk_en)
    `CHK("lps osc16", 1'b1, internal_16m_osc)
    irq_or_event = 1'b1; wait_ev(0, 20, n); irq_or_event = 1'b0;
    req(REQ_RUN);
    // Batch acquisition at 2 MHz from run
    batch_acquisition_submode = 1'b1; req(REQ_SLEEP);
    `CHK("batch main", 1'b0, main_regulator_state)
    `CHK("batch clks", 4'b1100, {dma_clk_en, comm_clk_en, other_periph_clk_en, flash_clk_en})
    `CHK("batch flash", 1'b1, flash_pd)
    irq_or_event = 1'b1; wait_ev(0, 20, n); irq_or_event = 1'b0;
    batch_acquisition_submode = 1'b0; req(REQ_RUN); sysclk_khz = 18'h00fa0;
    // Stop modes with peripheral wakeups
    for (int i = 0; i < 4; i++) begin
      resume_in_flash = (i == 3); req(stops[i]);
      `CHK("stop fast", 1'b0, fast_osc_en)
      `CHK("stop main", i == 0, main_regulator_state)
      `CHK("stop brownout", 1'b1, brownout_reset & independent_watchdog)
      periph_osc_req = 1'b1; repeat (2) @(negedge clk_sys);
      `CHK("osc16 on demand", 1'b1, internal_16m_osc)
      periph_osc_req = 1'b0; serial_start = (i == 0); i2c_addr_match = (i == 1);
      serial_addr = (i == 2); serial_frame = (i == 3);
      @(negedge clk_sys);
      if (i == 1) `CHK("i2c irq", 1'b1, i2c_wake_irq)
      else `CHK("serial irq", 1'b1, serial_wake_irq)
      wait_ev(0, lims[i] + 20, n); {serial_start, serial_addr, serial_frame, i2c_addr_match} = '0;
      `CHK("stop wake time", 1'b1, n + 2 >= lims[i] && n + 2 <= lims[i] + 12)
      `CHK("multispeed restart", 1'b1, multispeed_internal_osc)
    end
    // Standby without and with SRAM2 retention
    pull_up_sel = 16'ha5c3; pull_dn_sel = 16'h0a30;
    for (int j = 0; j < 2; j++) begin
      sram2_retain_sel = j[0]; req(REQ_STANDBY);
      `CHK("sby sram", {1'b0, j[0]}, {sram1_pwr, sram2_pwr})
      `CHK("sby brownout", 1'b1, brownout_reset)
      `CHK("sby pulls", {pull_up_sel, pull_dn_sel}, {pull_up_out, pull_dn_out})
      irq_or_event = 1'b1; no_wake; irq_or_event = 1'b0;
      `CHK("sby irq ignored", 1'b0, hit)
      wakeup_pin = j[0] ? 5'h10 : 5'h00; wdg_wake = !j[0];
      wait_ev(1, 20, n); wakeup_pin = 5'h00; wdg_wake = 1'b0;
      `CHK("sby restart", 1'b1, cpu_clk_en)
    end
    // Shutdown: watchdog and fast-clock rtc ignored, then crystal rtc or reset pin
    for (int k = 0; k < 2; k++) begin
      rtc_on_slow_crystal = 1'b0; req(REQ_SHUTDOWN);
      `CHK("sd off", 3'h0, {brownout_reset, main_regulator_state, lowpower_regulator_state})
      `CHK("sd wdg", 1'b0, independent_watchdog)
      wdg_wake = 1'b1; rtc_wake = 1'b1; no_wake; wdg_wake = 1'b0;
      `CHK("sd bad wake", 1'b0, hit)
      rtc_on_slow_crystal = !k[0]; rtc_wake = !k[0]; reset_pin_n = !k[0];
      wait_ev(1, 20, n); rtc_wake = 1'b0; reset_pin_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      `CHK("sd pulls lost", 32'h0, {pull_up_out, pull_dn_out})
    end
    // Reset in deep stop: run values at once, requests taken after release
    req(REQ_STOP_DEEP); rst = 1'b1; @(negedge clk_sys);
    `CHK("rst in stop", 3'h7, {cpu_clk_en, fast_osc_en, brownout_reset})
    rst = 1'b0; repeat (2) @(negedge clk_sys); req(REQ_SLEEP);
    `CHK("sleep after rst", 1'b0, cpu_clk_en)
    give_verdict;
  end

  // Overall run limit
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    give_verdict;
  end
endmodule // low_power_mode_control_tb
